// >>> verilog/dcp_pkg.sv
// Constants and types for the drive control path selector
package dcp_pkg;
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_CFG      = 5'h04;
  localparam logic [4:0]  REG_EXT1     = 5'h08;
  localparam logic [4:0]  REG_EXT2     = 5'h0c;
  localparam logic [4:0]  REG_TIMEOUT  = 5'h10;
  localparam logic [4:0]  REG_STATUS   = 5'h14;
  localparam logic [4:0]  REG_SLAVE    = 5'h18;
  localparam int          CW_LINK_CMD  = 0;
  localparam int          CW_LINK_REF  = 1;
  localparam int          CW_REF_SEL   = 4;
  localparam int          CW_FAR       = 10;
  localparam int          CW_TERM      = 11;
  localparam int          CFG_BASE_LO  = 0;
  localparam int          CFG_MEANS_LO = 4;
  localparam int          CFG_NEAR_LO  = 8;
  localparam int          CFG_FAR_LO   = 12;
  localparam int          CFG_SHOW     = 16;
  localparam int          CFG_ASCII    = 17;
  localparam int          ST_CLR_FAULT = 0;
  localparam logic [31:0] CTRL_RST     = 32'h0;
  localparam logic [31:0] CFG_RST      = 32'h0;
  localparam logic [15:0] EXT_RST      = 16'h0;
  localparam logic [15:0] TIMEOUT_RST  = 16'h0;
  localparam logic [7:0]  SLAVE_RST    = 8'h01;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam logic [7:0]  MAX_SLAVE    = 8'hf7;
  localparam logic [7:0]  FN_READ_HOLD = 8'h03;
  localparam logic [7:0]  FN_WRITE_ONE = 8'h06;
  localparam logic [7:0]  FN_WRITE_MUL = 8'h10;
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SRC_PAD, SRC_TERMINAL, SRC_LINK} dcp_src_t;
  typedef enum logic [2:0] {
    PATH_PAD_BOTH, PATH_TERMINAL_BOTH, PATH_PAD_CMD_TERM_REF,
    PATH_TERM_CMD_PAD_REF, PATH_BY_INPUT, PATH_BY_KEY, PATH_BY_LINK
  } dcp_base_t;
  typedef enum logic [1:0] {
    MODE_NONE, MODE_BY_INPUT, MODE_BY_FUNCTION_KEY, MODE_BY_LINK_BIT
  } dcp_means_t;
  typedef enum logic [1:0] {
    NEAR_PAD_BOTH, NEAR_LINK_BOTH, NEAR_NORMAL_REF_LINK_CMD,
    NEAR_NORMAL_NON_LINK
  } dcp_near_t;
  typedef enum logic [2:0] {
    FAR_TERMINAL_BOTH, FAR_PAD_REF_TERMINAL_CMD, FAR_TERMINAL_REF_PAD_CMD,
    FAR_NORMAL_REF_LINK_CMD, FAR_TERMINAL_CMD_LINK_REF, FAR_LINK_FULL
  } dcp_far_t;
  typedef struct packed {
    dcp_src_t ref_src;
    dcp_src_t cmd_src;
  } dcp_path_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] func;
  } dcp_frame_t;
endpackage

// >>> verilog/dcp_path_select.sv
// Control path selector with Avalon-MM register slave
module dcp_path_select import dcp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Drive inputs
  input  wire logic        mode_in,
  input  wire logic        mode_key,
  input  wire logic        path_in,
  input  wire logic        path_key,
  input  wire logic        link_override_input,
  input  wire logic        pad_enhanced,
  // Decoded serial frame header
  input  wire dcp_frame_t  frm_i,
  output logic             frm_accept,
  output logic             frm_reply,
  output logic             frm_exception,
  // Selection results
  output dcp_path_t        path_q,
  output logic             ref_second,
  output logic      [15:0] ref_value,
  output logic             near_indicator,
  output logic             far_indicator,
  output logic             link_fault,
  output logic             show_addr,
  output logic             ascii_mode
);
  localparam int TW = $clog2(MS_CYC);
  generate
    if (MS_CYC < 2) begin : g_bad
      $error("MS_CYC must be at least 2");
    end
  endgenerate

  logic [31:0]   ctrl_q;
  logic [31:0]   cfg_q;
  logic [15:0]   ext1_q;
  logic [15:0]   ext2_q;
  logic [15:0]   timeout_q;
  logic [7:0]    slave_q;
  logic          ack_q;
  logic          far_q;
  logic          term_tog_q;
  logic [TW-1:0] tick_q;
  logic [15:0]   idle_q;
  logic          wr_en;
  logic          fault_set;
  dcp_path_t     path_d;
  dcp_path_t     base_p;
  dcp_path_t     link_p;
  dcp_base_t     base_sel;
  dcp_means_t    means;
  dcp_near_t     near_sel;
  dcp_far_t      far_sel;
  logic          lr_mode;
  logic          fn_ok;
  logic          for_us;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic [31:0] cfg_force(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (dcp_far_t'(v[CFG_FAR_LO +: 3]) == FAR_LINK_FULL) begin
      r[CFG_NEAR_LO +: 2] = NEAR_NORMAL_NON_LINK;
    end else if (dcp_near_t'(v[CFG_NEAR_LO +: 2]) == NEAR_NORMAL_NON_LINK)
    begin
      r[CFG_FAR_LO +: 3] = FAR_LINK_FULL;
    end
    return r;
  endfunction

  function automatic dcp_path_t both(input dcp_src_t s);
    dcp_path_t p;
    p.ref_src = s;
    p.cmd_src = s;
    return p;
  endfunction
  // One wait state: request taken on the edge where ack_q is high
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_en           = avs_write & ack_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~ack_q) begin
      if (avs_address == REG_CTRL) begin
        avs_readdata <= ctrl_q;
      end else if (avs_address == REG_CFG) begin
        avs_readdata <= cfg_q;
      end else if (avs_address == REG_EXT1) begin
        avs_readdata <= {16'h0, ext1_q};
      end else if (avs_address == REG_EXT2) begin
        avs_readdata <= {16'h0, ext2_q};
      end else if (avs_address == REG_TIMEOUT) begin
        avs_readdata <= {16'h0, timeout_q};
      end else if (avs_address == REG_STATUS) begin
        avs_readdata <= {23'h0, show_addr, near_indicator, far_indicator,
                         ref_second, path_q, link_fault};
      end else if (avs_address == REG_SLAVE) begin
        avs_readdata <= {24'h0, slave_q};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= CTRL_RST;
      cfg_q     <= CFG_RST;
      ext1_q    <= EXT_RST;
      ext2_q    <= EXT_RST;
      timeout_q <= TIMEOUT_RST;
    end else if (wr_en) begin
      if (avs_address == REG_CTRL) begin
        ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_CFG) begin
        cfg_q <= cfg_force(be_merge(cfg_q, avs_writedata, avs_byteenable));
      end else if (avs_address == REG_EXT1) begin
        ext1_q <= 16'(be_merge({16'h0, ext1_q}, avs_writedata,
                               avs_byteenable));
      end else if (avs_address == REG_EXT2) begin
        ext2_q <= 16'(be_merge({16'h0, ext2_q}, avs_writedata,
                               avs_byteenable));
      end else if (avs_address == REG_TIMEOUT) begin
        timeout_q <= 16'(be_merge({16'h0, timeout_q}, avs_writedata,
                                  avs_byteenable));
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slave_q <= SLAVE_RST;
    end else if (wr_en && avs_address == REG_SLAVE && avs_byteenable[0] &&
                 avs_writedata[7:0] != BCAST_ADDR &&
                 avs_writedata[7:0] <= MAX_SLAVE) begin
      slave_q <= avs_writedata[7:0];
    end
  end

  assign base_sel = dcp_base_t'(cfg_q[CFG_BASE_LO +: 3]);
  assign means    = dcp_means_t'(cfg_q[CFG_MEANS_LO +: 2]);
  assign near_sel = dcp_near_t'(cfg_q[CFG_NEAR_LO +: 2]);
  assign far_sel  = dcp_far_t'(cfg_q[CFG_FAR_LO +: 3]);
  assign lr_mode  = means != MODE_NONE;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      far_q <= 1'b0;
    end else begin
      case (means)
        MODE_BY_INPUT:        far_q <= mode_in;
        MODE_BY_FUNCTION_KEY: far_q <= far_q ^ mode_key;
        MODE_BY_LINK_BIT:     far_q <= ctrl_q[CW_FAR];
        default:              far_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      term_tog_q <= 1'b0;
    end else if (path_key) begin
      term_tog_q <= ~term_tog_q;
    end
  end
  // Base path; in PATH_BY_LINK, bit 11 chooses pad or terminal
  always_comb begin
    case (base_sel)
      PATH_TERMINAL_BOTH: base_p = both(SRC_TERMINAL);
      PATH_PAD_CMD_TERM_REF: begin
        base_p.ref_src = SRC_TERMINAL;
        base_p.cmd_src = SRC_PAD;
      end
      PATH_TERM_CMD_PAD_REF: begin
        base_p.ref_src = SRC_PAD;
        base_p.cmd_src = SRC_TERMINAL;
      end
      PATH_BY_INPUT: base_p = both(path_in ? SRC_TERMINAL : SRC_PAD);
      PATH_BY_KEY:   base_p = both(term_tog_q ? SRC_TERMINAL : SRC_PAD);
      PATH_BY_LINK:  base_p = both(ctrl_q[CW_TERM] ? SRC_TERMINAL : SRC_PAD);
      default:       base_p = both(SRC_PAD);
    endcase
  end
  // command bits hand paths to the link
  always_comb begin
    link_p = base_p;
    if (ctrl_q[CW_LINK_CMD]) begin
      link_p.cmd_src = SRC_LINK;
    end
    if (ctrl_q[CW_LINK_REF]) begin
      link_p.ref_src = SRC_LINK;
    end
  end
  // override only acts without the near/far scheme
  always_comb begin
    path_d = link_p;
    if (!lr_mode) begin
      // override reverts to the base path
      path_d = link_override_input ? base_p : link_p;
    end else if (!far_q) begin
      case (near_sel)
        NEAR_PAD_BOTH:  path_d = both(SRC_PAD);
        NEAR_LINK_BOTH: path_d = both(SRC_LINK);
        NEAR_NORMAL_REF_LINK_CMD: begin
          path_d.ref_src = base_p.ref_src;
          path_d.cmd_src = SRC_LINK;
        end
        default: path_d = link_p;
      endcase
    end else begin
      case (far_sel)
        FAR_TERMINAL_BOTH: path_d = both(SRC_TERMINAL);
        FAR_PAD_REF_TERMINAL_CMD: begin
          path_d.ref_src = SRC_PAD;
          path_d.cmd_src = SRC_TERMINAL;
        end
        FAR_TERMINAL_REF_PAD_CMD: begin
          path_d.ref_src = SRC_TERMINAL;
          path_d.cmd_src = SRC_PAD;
        end
        FAR_NORMAL_REF_LINK_CMD: begin
          path_d.ref_src = base_p.ref_src;
          path_d.cmd_src = SRC_LINK;
        end
        FAR_TERMINAL_CMD_LINK_REF: begin
          path_d.ref_src = SRC_LINK;
          path_d.cmd_src = SRC_TERMINAL;
        end
        default: path_d = link_p;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      path_q         <= '{SRC_PAD, SRC_PAD};
      near_indicator <= 1'b0;
      far_indicator  <= 1'b0;
      show_addr      <= 1'b0;
      ascii_mode     <= 1'b0;
    end else begin
      path_q         <= path_d;
      near_indicator <= lr_mode & ~far_q;
      far_indicator  <= lr_mode & far_q;
      show_addr      <= pad_enhanced | cfg_q[CFG_SHOW];
      ascii_mode     <= cfg_q[CFG_ASCII];
    end
  end
  // external reference choice; holds last value otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_second <= 1'b0;
      ref_value  <= EXT_RST;
    end else begin
      ref_second <= ctrl_q[CW_REF_SEL];
      if (path_d.ref_src == SRC_LINK && !link_fault) begin
        ref_value <= ctrl_q[CW_REF_SEL] ? ext2_q : ext1_q;
      end
    end
  end
  // Millisecond tick and idle time since the last command word write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
      idle_q <= 16'h0;
    end else begin
      tick_q <= (tick_q == TW'(MS_CYC - 1)) ? '0 : tick_q + 1'b1;
      if (wr_en && avs_address == REG_CTRL) begin
        idle_q <= 16'h0;
      end else if (tick_q == TW'(MS_CYC - 1) && idle_q != 16'hffff) begin
        idle_q <= idle_q + 16'h1;
      end
    end
  end
  // fault only when a timeout is set; set wins over clear
  assign fault_set = timeout_q != 16'h0 && idle_q >= timeout_q &&
                     (path_q.ref_src == SRC_LINK ||
                      path_q.cmd_src == SRC_LINK);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_fault <= 1'b0;
    end else if (fault_set) begin
      link_fault <= 1'b1;
    end else if (wr_en && avs_address == REG_STATUS &&
                 avs_byteenable[0] && avs_writedata[ST_CLR_FAULT]) begin
      link_fault <= 1'b0;
    end
  end
  assign fn_ok  = frm_i.func == FN_READ_HOLD ||
                  frm_i.func == FN_WRITE_ONE ||
                  frm_i.func == FN_WRITE_MUL;
  assign for_us = frm_i.valid &&
                  (frm_i.addr == slave_q || frm_i.addr == BCAST_ADDR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frm_accept    <= 1'b0;
      frm_reply     <= 1'b0;
      frm_exception <= 1'b0;
    end else begin
      frm_accept    <= for_us & fn_ok;
      frm_reply     <= for_us & (frm_i.addr != BCAST_ADDR);
      frm_exception <= for_us & ~fn_ok & (frm_i.addr != BCAST_ADDR);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_link_cmd;
    (!lr_mode && !link_override_input && ctrl_q[CW_LINK_CMD])
      |=> path_q.cmd_src == SRC_LINK;
  endproperty
  a_link_cmd: assert property (p_link_cmd) else $error("link cmd");
  property p_override;
    (!lr_mode && link_override_input) |=> path_q == $past(base_p);
  endproperty
  a_override: assert property (p_override) else $error("override");
  property p_mode_input;
    (means == MODE_BY_INPUT) |=> far_q == $past(mode_in);
  endproperty
  a_mode_input: assert property (p_mode_input) else $error("mode in");
  property p_key_toggle;
    (means == MODE_BY_FUNCTION_KEY && mode_key) |=> far_q != $past(far_q);
  endproperty
  a_key_toggle: assert property (p_key_toggle) else $error("toggle");
  property p_indicator;
    (lr_mode && $stable(far_q)) ##1 lr_mode
      |=> (near_indicator ^ far_indicator) && far_indicator == $past(far_q);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator");
  property p_bcast;
    (frm_i.valid && frm_i.addr == BCAST_ADDR) |=> !frm_reply;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast reply");
  property p_reply;
    (frm_i.valid && frm_i.addr == slave_q && fn_ok)
      |=> frm_reply && frm_accept && !frm_exception;
  endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_force;
    (far_sel == FAR_LINK_FULL) |-> near_sel == NEAR_NORMAL_NON_LINK;
  endproperty
  a_force: assert property (p_force) else $error("near not forced");
  property p_no_fault;
    (timeout_q == 16'h0 && !link_fault) |=> !link_fault;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("stray fault");
  property p_wait;
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
endmodule

// >>> test/dcp_avm_model.sv
// Avalon-MM master model standing in for the serial-side requester
module dcp_avm_model (
  // Clock
  input  wire logic        mclk,
  // Avalon-MM master
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    address    = 5'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'hf;
  end

  // Released address and data lines flip so a stale value is never mistaken for a live one
  task automatic release_bus();
    read      <= 1'b0;
    write     <= 1'b0;
    writedata <= ~writedata;
    address   <= ~address;
  endtask

  // Waitrequest is sampled as it stood at the edge, before updates land
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    @(posedge mclk iff waitrequest === 1'b0);
    release_bus();
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    address <= a;
    read    <= 1'b1;
    @(posedge mclk iff waitrequest === 1'b0);
    d = readdata;
    release_bus();
  endtask
endmodule

// >>> test/dcp_path_select_tb_top.sv
// Self-checking bench for the control path selector
module dcp_path_select_tb_top import dcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] BASE_EXP = 16'h1450;
  localparam logic [11:0] NEAR_EXP = 12'h2a0;
  localparam logic [19:0] FAR_EXP  = 20'h92415;

  logic        mclk, rst, rd_, wr_, wait_q, mode_in, mode_key;
  logic        path_in, path_key, ovr, pad_enh, accept, reply, exc;
  logic        ref_second, near_ind, far_ind, link_fault, show, ascii;
  logic [4:0]  address;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [15:0] ref_value;
  dcp_frame_t  frm;
  dcp_path_t   path_q;
  int          miscompares, check_count;
  int          cyc = 0;

  dcp_avm_model dcp_avm_model_inst (
    .mclk(mclk), .address(address), .read(rd_), .write(wr_),
    .writedata(wdata), .byteenable(be), .readdata(rdata),
    .waitrequest(wait_q));

  // A short millisecond keeps the link-loss wait small
  dcp_path_select #(.MS_CYC(4)) dcp_path_select_inst (
    .mclk(mclk), .rst(rst), .avs_address(address), .avs_read(rd_),
    .avs_write(wr_), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_q), .mode_in(mode_in),
    .mode_key(mode_key), .path_in(path_in), .path_key(path_key),
    .link_override_input(ovr), .pad_enhanced(pad_enh), .frm_i(frm),
    .frm_accept(accept), .frm_reply(reply), .frm_exception(exc),
    .path_q(path_q), .ref_second(ref_second), .ref_value(ref_value),
    .near_indicator(near_ind), .far_indicator(far_ind),
    .link_fault(link_fault), .show_addr(show), .ascii_mode(ascii));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("Counts: checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    dcp_avm_model_inst.wr(a, d);
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    dcp_avm_model_inst.rd(a, d);
    chk(d, exp);
  endtask

  // Path outputs lag a register write by one cycle, two when it goes through far_q
  task automatic set(input logic [31:0] cfg, input logic [31:0] ctrl);
    wr(REG_CFG, cfg);
    wr(REG_CTRL, ctrl);
    tick(3);
  endtask

  task automatic pulse(input bit mode_pin);
    @(posedge mclk);
    if (mode_pin) mode_key <= 1'b1;
    else path_key <= 1'b1;
    @(posedge mclk);
    mode_key <= 1'b0;
    path_key <= 1'b0;
    tick(3);
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] f,
                       input logic [2:0] e);
    @(posedge mclk);
    frm <= '{1'b1, a, f};
    @(posedge mclk);
    frm <= '{1'b0, 8'h00, 8'h00};
    #1;
    chk({accept, reply, exc}, e);
  endtask

  task automatic t_reset();
    chk(path_q, 4'h0);
    chk({near_ind, far_ind}, 2'b00);
    chk_rd(REG_SLAVE, 32'h1);
    chk_rd(REG_CFG, CFG_RST);
    wr(5'h1c, 32'hffff_ffff);
    chk_rd(5'h1c, 32'h0);
  endtask

  task automatic t_base();
    for (int i = 0; i < 4; i++) begin
      set(32'(i), 32'h0);
      chk(path_q, BASE_EXP[i*4 +: 4]);
    end
    set(32'h6, 32'h0);
    chk(path_q, 4'h0);
    set(32'h6, 32'h800);
    chk(path_q, 4'h5);
    set(32'h0, 32'h1);
    chk(path_q, 4'h2);
    set(32'h0, 32'h2);
    chk(path_q, 4'h8);
    set(32'h4, 32'h0);
    @(posedge mclk) path_in <= 1'b1;
    tick(3);
    chk(path_q, 4'h5);
    @(posedge mclk) path_in <= 1'b0;
    set(32'h5, 32'h0);
    pulse(1'b0);
    chk(path_q, 4'h5);
  endtask

  task automatic t_override();
    set(32'h1, 32'h3);
    chk(path_q, 4'ha);
    @(posedge mclk) ovr <= 1'b1;
    tick(3);
    chk(path_q, 4'h5);
    @(posedge mclk) ovr <= 1'b0;
  endtask

  task automatic t_link_mode();
    for (int n = 0; n < 3; n++) begin
      set(32'h30 | (32'(n) << 8), 32'h0);
      chk(path_q, NEAR_EXP[n*4 +: 4]);
      chk({near_ind, far_ind}, 2'b10);
    end
    @(posedge mclk) ovr <= 1'b1;
    for (int f = 0; f < 5; f++) begin
      set(32'h30 | (32'(f) << 12), 32'h400);
      chk(path_q, FAR_EXP[f*4 +: 4]);
      chk({near_ind, far_ind}, 2'b01);
    end
    @(posedge mclk) ovr <= 1'b0;
  endtask

  task automatic t_force();
    wr(REG_CFG, 32'h5030);
    chk_rd(REG_CFG, 32'h5330);
    wr(REG_CFG, 32'h0330);
    chk_rd(REG_CFG, 32'h5330);
    wr(REG_CTRL, 32'h0);
    tick(3);
    chk(path_q, 4'h0);
  endtask

  task automatic t_input_key();
    set(32'h10, 32'h0);
    @(posedge mclk) mode_in <= 1'b1;
    tick(3);
    chk({near_ind, far_ind}, 2'b01);
    @(posedge mclk) mode_in <= 1'b0;
    tick(3);
    chk({near_ind, far_ind}, 2'b10);
    set(32'h20, 32'h0);
    pulse(1'b1);
    chk({near_ind, far_ind}, 2'b01);
    pulse(1'b1);
    chk({near_ind, far_ind}, 2'b10);
  endtask

  task automatic t_ref_loss();
    wr(REG_EXT1, 32'h1234);
    wr(REG_EXT2, 32'habcd);
    set(32'h0, 32'h2);
    chk({ref_second, ref_value}, 17'h01234);
    set(32'h0, 32'h12);
    chk({ref_second, ref_value}, 17'h1abcd);
    wr(REG_TIMEOUT, 32'h4);
    wr(REG_CTRL, 32'h12);
    tick(2);
    chk(link_fault, 1'b0);
    tick(30);
    chk(link_fault, 1'b1);
    chk_rd(REG_STATUS, 32'h31);
    wr(REG_TIMEOUT, 32'h0);
    wr(REG_STATUS, 32'h1);
    tick(30);
    chk(link_fault, 1'b0);
    chk(ref_value, 16'habcd);
    set(32'h0, 32'h0);
  endtask

  task automatic t_frames();
    wr(REG_SLAVE, 32'h5);
    wr(REG_SLAVE, 32'hf8);
    chk_rd(REG_SLAVE, 32'h5);
    wr(REG_SLAVE, 32'h0);
    chk_rd(REG_SLAVE, 32'h5);
    frame(8'h05, FN_READ_HOLD, 3'b110);
    frame(8'h05, FN_WRITE_ONE, 3'b110);
    frame(8'h05, FN_WRITE_MUL, 3'b110);
    frame(8'h05, 8'h04, 3'b011);
    frame(BCAST_ADDR, FN_WRITE_MUL, 3'b100);
    frame(8'h09, FN_READ_HOLD, 3'b000);
  endtask

  task automatic t_show();
    chk(show, 1'b0);
    wr(REG_CFG, 32'h10000);
    tick(3);
    chk(show, 1'b1);
    wr(REG_CFG, 32'h20000);
    tick(3);
    chk({show, ascii}, 2'b01);
    @(posedge mclk) pad_enh <= 1'b1;
    tick(3);
    chk(show, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    mode_in = 1'b0;
    mode_key = 1'b0;
    path_in = 1'b0;
    path_key = 1'b0;
    ovr = 1'b0;
    pad_enh = 1'b0;
    frm = '{1'b0, 8'h00, 8'h00};
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_base();
    t_override();
    t_link_mode();
    t_force();
    t_input_key();
    t_ref_loss();
    t_frames();
    t_show();
    end_sim();
  end
endmodule
